// ===== logic/rmrp_pkg.sv
package rmrp_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [6:0] IDX_DATA_FIFO_PORT     = 7'h00;
   localparam logic [6:0] IDX_OPERATING_MODE     = 7'h01;
   localparam logic [6:0] IDX_RESERVED_FIRST     = 7'h02;
   localparam logic [6:0] IDX_RESERVED_LAST      = 7'h05;
   localparam logic [6:0] IDX_CARRIER_FREQ_HIGH  = 7'h06;
   localparam logic [6:0] IDX_MODEM_PAGE_FIRST   = 7'h07;
   localparam logic [6:0] IDX_SHARED_FIRST       = 7'h0d;
   localparam logic [6:0] IDX_SHARED_LAST        = 7'h3f;
   localparam logic [6:0] IDX_MODEM_PAGE_LAST    = 7'h60;
   localparam logic [6:0] IDX_BANK_FIRST         = 7'h61;
   localparam logic [6:0] IDX_HF_GAIN_REF        = 7'h61;
   localparam logic [6:0] IDX_HF_GAIN_THR_ONE    = 7'h62;
   localparam logic [6:0] IDX_HF_GAIN_THR_TWO    = 7'h63;
   localparam logic [6:0] IDX_HF_GAIN_THR_THREE  = 7'h64;
   localparam logic [6:0] IDX_HF_SYNTH_LOOP      = 7'h70;
   localparam logic [6:0] IDX_BANK_LAST          = 7'h73;

   // ----------------------------------------------------------------
   // operating mode control field positions
   // ----------------------------------------------------------------
   localparam int POS_MODEM_SELECT = 7;
   localparam int POS_SHARED_PAGE  = 6;
   localparam int POS_BAND_BANK    = 3;
   localparam int POS_MODE_MSB     = 2;
   localparam int POS_LF_BANK_SLOT = 1;

   // ----------------------------------------------------------------
   // device modes and bus handshake states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      sleep_state            = 3'b000,
      standby_state          = 3'b001,
      tx_synth_state         = 3'b010,
      transmit_state         = 3'b011,
      rx_synth_state         = 3'b100,
      rx_continuous_state    = 3'b101,
      rx_one_shot_state      = 3'b110,
      channel_activity_state = 3'b111
   } rmrp_mode_t;

   typedef enum logic [0:0] {
      bus_idle    = 1'b0,
      bus_ext_ack = 1'b1
   } rmrp_bus_t;

   // one band-specific bank of registers
   typedef struct packed {
      logic [5:0] gain_floor_level;
      logic [4:0] gain_thr_one;
      logic [7:0] gain_thr_two;
      logic [7:0] gain_thr_three;
      logic [7:0] synth_loop;
   } rmrp_bank_t;

   typedef struct packed {
      rmrp_bus_t        bus;
      logic             modem_select;
      logic             shared_page_access;
      logic             band_bank_select;
      rmrp_mode_t       mode;
      logic             mode_start;
      logic [7:0]       fifo_data;
      logic [7:0]       carrier_freq_high;
      rmrp_bank_t [1:0] bank;
      logic             ext_req;
      logic             ext_we;
      logic [6:0]       ext_addr;
      logic [7:0]       ext_wdata;
      logic             ext_fsk_page;
   } rmrp_state_t;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_OPERATING_MODE   = 8'h09;
   localparam logic [7:0] RST_DATA_FIFO_PORT   = 8'h00;
   localparam logic [7:0] RST_CARRIER_FREQ     = 8'h6c;
   localparam logic [7:0] RST_SYNTH_LOOP       = 8'hd0;

   localparam rmrp_bank_t RST_HF_BANK = '{
      gain_floor_level: 6'h1c, gain_thr_one: 5'h0e, gain_thr_two: 8'h5b,
      gain_thr_three: 8'hcc, synth_loop: RST_SYNTH_LOOP};
   localparam rmrp_bank_t RST_LF_BANK = '{
      gain_floor_level: 6'h19, gain_thr_one: 5'h0c, gain_thr_two: 8'h4b,
      gain_thr_three: 8'hcc, synth_loop: RST_SYNTH_LOOP};

   localparam rmrp_state_t RST_STATE = '{
      bus: bus_idle, modem_select: 1'b0, shared_page_access: 1'b0,
      band_bank_select: 1'b1, mode: standby_state, mode_start: 1'b0,
      fifo_data: RST_DATA_FIFO_PORT, carrier_freq_high: RST_CARRIER_FREQ,
      bank: '{RST_LF_BANK, RST_HF_BANK}, ext_req: 1'b0, ext_we: 1'b0,
      ext_addr: 7'h00, ext_wdata: 8'h00, ext_fsk_page: 1'b1};

endpackage

// ===== logic/rmrp_regs.sv
module rmrp_regs (
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [8:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output      logic [31:0] prdata_o,
   output      logic        pready_o,
   output      logic        pslverr_o,
   output      logic        ext_req_o,
   output      logic        ext_we_o,
   output      logic [6:0]  ext_addr_o,
   output      logic [7:0]  ext_wdata_o,
   output      logic        ext_fsk_page_o,
   input  wire logic [7:0]  ext_rdata_i,
   output      logic        modem_select_o,
   output      logic        band_bank_select_o,
   output      logic [2:0]  mode_o,
   output      logic        mode_start_o,
   output      logic [7:0]  carrier_freq_high_o,
   output      logic [5:0]  gain_floor_level_o,
   output      logic [4:0]  gain_threshold_first_o,
   output      logic [3:0]  gain_threshold_second_o,
   output      logic [3:0]  gain_threshold_third_o,
   output      logic [3:0]  gain_threshold_fourth_o,
   output      logic [3:0]  gain_threshold_fifth_o,
   output      logic [1:0]  synth_loop_bandwidth_o
);

   rmrp_pkg::rmrp_state_t q;
   rmrp_pkg::rmrp_state_t d;
   logic [6:0]            idx;
   logic                  access;
   logic                  misaligned;
   logic                  fifo_locked;
   logic                  bad;
   logic                  is_ext;
   logic                  is_shared;
   logic                  wr_local;
   logic [7:0]            local_rdata;
   logic                  slot;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // misaligned byte addresses answer with an error instead of aliasing
   assign idx        = paddr_i[8:2];
   assign access     = psel_i & penable_i;
   assign misaligned = (paddr_i[1:0] != 2'b00);
   assign fifo_locked = (idx == rmrp_pkg::IDX_DATA_FIFO_PORT) &&
                        (q.mode == rmrp_pkg::sleep_state);
   assign bad        = misaligned | fifo_locked;
   assign is_ext     = ((idx >= rmrp_pkg::IDX_MODEM_PAGE_FIRST) &&
                        (idx <= rmrp_pkg::IDX_MODEM_PAGE_LAST)) ||
                       (idx > rmrp_pkg::IDX_BANK_LAST);
   assign is_shared  = (idx >= rmrp_pkg::IDX_SHARED_FIRST) &&
                       (idx <= rmrp_pkg::IDX_SHARED_LAST);
   // band bit 1 selects the low band slot, 0 the high band slot
   assign slot       = q.band_bank_select;

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   // local registers answer with no wait; the modem pages need one extra
   // cycle so the far side can return its byte from a registered request
   assign pready_o  = access & (bad | ~is_ext | (q.bus == rmrp_pkg::bus_ext_ack));
   assign pslverr_o = access & pready_o & bad;
   assign wr_local  = access & pwrite_i & ~bad & ~is_ext;

   // local read mux, reserved and unused bits read zero
   always_comb begin
      local_rdata = 8'h00;
      case (idx)
         rmrp_pkg::IDX_DATA_FIFO_PORT: begin
            local_rdata = q.fifo_data;
         end
         rmrp_pkg::IDX_OPERATING_MODE: begin
            local_rdata = {q.modem_select, q.shared_page_access, 2'b00,
                           q.band_bank_select, q.mode};
         end
         rmrp_pkg::IDX_CARRIER_FREQ_HIGH: begin
            local_rdata = q.carrier_freq_high;
         end
         rmrp_pkg::IDX_HF_GAIN_REF: begin
            local_rdata = {2'b00, q.bank[slot].gain_floor_level};
         end
         rmrp_pkg::IDX_HF_GAIN_THR_ONE: begin
            local_rdata = {3'b000, q.bank[slot].gain_thr_one};
         end
         rmrp_pkg::IDX_HF_GAIN_THR_TWO: begin
            local_rdata = q.bank[slot].gain_thr_two;
         end
         rmrp_pkg::IDX_HF_GAIN_THR_THREE: begin
            local_rdata = q.bank[slot].gain_thr_three;
         end
         rmrp_pkg::IDX_HF_SYNTH_LOOP: begin
            local_rdata = q.bank[slot].synth_loop;
         end
         default: begin
            local_rdata = 8'h00;
         end
      endcase
   end

   // read data, upper 24 bits are always zero
   always_comb begin
      prdata_o = 32'h0000_0000;
      if (access && pready_o && !bad && !pwrite_i) begin
         if (is_ext) begin
            prdata_o = {24'h00_0000, ext_rdata_i};
         end else begin
            prdata_o = {24'h00_0000, local_rdata};
         end
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d            = q;
      d.ext_req    = 1'b0;
      d.mode_start = 1'b0;

      // modem page requests: page tag follows modem and shared bits
      case (q.bus)
         rmrp_pkg::bus_idle: begin
            if (access && is_ext && !bad) begin
               d.ext_req   = 1'b1;
               d.ext_we    = pwrite_i;
               d.ext_addr  = idx;
               d.ext_wdata = pwdata_i[7:0];
               d.bus       = rmrp_pkg::bus_ext_ack;
               if (!q.modem_select) begin
                  d.ext_fsk_page = 1'b1;
               end else if (is_shared && q.shared_page_access) begin
                  d.ext_fsk_page = 1'b1;
               end else begin
                  d.ext_fsk_page = 1'b0;
               end
            end
         end
         rmrp_pkg::bus_ext_ack: begin
            d.bus = rmrp_pkg::bus_idle;
         end
         default: begin
            d.bus = rmrp_pkg::bus_idle;
         end
      endcase

      // local register writes
      if (wr_local) begin
         case (idx)
            rmrp_pkg::IDX_DATA_FIFO_PORT: begin
               d.fifo_data = pwdata_i[7:0];
            end
            rmrp_pkg::IDX_OPERATING_MODE: begin
               // the mode in force before this write decides the lock
               if (q.mode == rmrp_pkg::sleep_state) begin
                  d.modem_select = pwdata_i[rmrp_pkg::POS_MODEM_SELECT];
               end
               d.shared_page_access = pwdata_i[rmrp_pkg::POS_SHARED_PAGE];
               d.band_bank_select   = pwdata_i[rmrp_pkg::POS_BAND_BANK];
               d.mode = rmrp_pkg::rmrp_mode_t'(pwdata_i[rmrp_pkg::POS_MODE_MSB:0]);
               d.mode_start = 1'b1;
            end
            rmrp_pkg::IDX_CARRIER_FREQ_HIGH: begin
               d.carrier_freq_high = pwdata_i[7:0];
            end
            rmrp_pkg::IDX_HF_GAIN_REF: begin
               d.bank[slot].gain_floor_level = pwdata_i[5:0];
            end
            rmrp_pkg::IDX_HF_GAIN_THR_ONE: begin
               d.bank[slot].gain_thr_one = pwdata_i[4:0];
            end
            rmrp_pkg::IDX_HF_GAIN_THR_TWO: begin
               d.bank[slot].gain_thr_two = pwdata_i[7:0];
            end
            rmrp_pkg::IDX_HF_GAIN_THR_THREE: begin
               d.bank[slot].gain_thr_three = pwdata_i[7:0];
            end
            rmrp_pkg::IDX_HF_SYNTH_LOOP: begin
               // low six bits are stored as written, software keeps them
               d.bank[slot].synth_loop = pwdata_i[7:0];
            end
            default: begin
               // reserved and unused indices: writes have no effect
               d.fifo_data = d.fifo_data;
            end
         endcase
      end

      // fifo content does not survive sleep
      if (q.mode == rmrp_pkg::sleep_state) begin
         d.fifo_data = rmrp_pkg::RST_DATA_FIFO_PORT;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         q <= rmrp_pkg::RST_STATE;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // the radio core follows whichever bank is selected
   assign ext_req_o               = q.ext_req;
   assign ext_we_o                = q.ext_we;
   assign ext_addr_o              = q.ext_addr;
   assign ext_wdata_o             = q.ext_wdata;
   assign ext_fsk_page_o          = q.ext_fsk_page;
   assign modem_select_o          = q.modem_select;
   assign band_bank_select_o      = q.band_bank_select;
   assign mode_o                  = q.mode;
   assign mode_start_o            = q.mode_start;
   assign carrier_freq_high_o     = q.carrier_freq_high;
   assign gain_floor_level_o      = q.bank[slot].gain_floor_level;
   assign gain_threshold_first_o  = q.bank[slot].gain_thr_one;
   assign gain_threshold_second_o = q.bank[slot].gain_thr_two[7:4];
   assign gain_threshold_third_o  = q.bank[slot].gain_thr_two[3:0];
   assign gain_threshold_fourth_o = q.bank[slot].gain_thr_three[7:4];
   assign gain_threshold_fifth_o  = q.bank[slot].gain_thr_three[3:0];
   assign synth_loop_bandwidth_o  = q.bank[slot].synth_loop[7:6];

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_modem_lock;
      @(posedge core_clk_i) disable iff (!resetn_i)
      $changed(q.modem_select) |-> $past(q.mode) == rmrp_pkg::sleep_state;
   endproperty
   a_modem_lock: assert property (p_modem_lock) else $error("modem select moved out of sleep");

   property p_page_tag;
      @(posedge core_clk_i) disable iff (!resetn_i)
      ext_req_o && !(ext_addr_o >= 7'h0d && ext_addr_o <= 7'h3f) |-> ext_fsk_page_o == !modem_select_o;
   endproperty
   a_page_tag: assert property (p_page_tag) else $error("page tag wrong outside shared range");

   property p_shared_page;
      @(posedge core_clk_i) disable iff (!resetn_i)
      access && !pwrite_i && is_ext && !bad && q.bus == rmrp_pkg::bus_idle && is_shared
      |=> ext_req_o && ext_fsk_page_o == (!q.modem_select || q.shared_page_access);
   endproperty
   a_shared_page: assert property (p_shared_page) else $error("shared page decode wrong");

   property p_bank_keep;
      @(posedge core_clk_i) disable iff (!resetn_i)
      wr_local && idx == 7'h61 |=> ($past(slot) ? $stable(q.bank[0]) : $stable(q.bank[1]));
   endproperty
   a_bank_keep: assert property (p_bank_keep) else $error("unselected bank changed");

   property p_mode_start;
      @(posedge core_clk_i) disable iff (!resetn_i)
      wr_local && idx == 7'h01 |=> mode_start_o && mode_o == $past(pwdata_i[2:0]) ##1 !mode_start_o;
   endproperty
   a_mode_start: assert property (p_mode_start) else $error("mode write did not start mode");

   property p_reset_mode;
      @(posedge core_clk_i) disable iff (!resetn_i)
      $past(!resetn_i) |-> !modem_select_o && band_bank_select_o && mode_o == 3'h1
         && !q.shared_page_access;
   endproperty
   a_reset_mode: assert property (p_reset_mode) else $error("mode register reset value wrong");

   property p_fifo_sleep;
      @(posedge core_clk_i) disable iff (!resetn_i)
      q.mode == rmrp_pkg::sleep_state ##1 q.mode == rmrp_pkg::sleep_state |-> q.fifo_data == 8'h00;
   endproperty
   a_fifo_sleep: assert property (p_fifo_sleep) else $error("fifo not cleared in sleep");

   property p_fifo_refuse;
      @(posedge core_clk_i) disable iff (!resetn_i)
      access && idx == 7'h00 && !misaligned && mode_o == 3'h0 |-> pready_o && pslverr_o;
   endproperty
   a_fifo_refuse: assert property (p_fifo_refuse) else $error("fifo access allowed in sleep");

   property p_reset_banks;
      @(posedge core_clk_i) disable iff (!resetn_i)
      $past(!resetn_i) |-> q.bank[0] == {6'h1c, 5'h0e, 8'h5b, 8'hcc, 8'hd0}
         && q.carrier_freq_high == 8'h6c;
   endproperty
   a_reset_banks: assert property (p_reset_banks) else $error("high bank reset values wrong");

   property p_ref_upper_zero;
      @(posedge core_clk_i) disable iff (!resetn_i)
      access && !pwrite_i && pready_o && idx == 7'h61 && !misaligned |-> prdata_o[31:6] == 26'h0;
   endproperty
   a_ref_upper_zero: assert property (p_ref_upper_zero) else $error("gain ref upper bits set");

   property p_reserved_zero;
      @(posedge core_clk_i) disable iff (!resetn_i)
      access && pready_o && !misaligned && idx >= 7'h02 && idx <= 7'h05
      |-> prdata_o == 32'h0 && !pslverr_o
         ##1 ($stable(q.fifo_data) || q.mode == rmrp_pkg::sleep_state);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved index not zero");

   property p_modem_hold;
      @(posedge core_clk_i) disable iff (!resetn_i)
      wr_local && idx == 7'h01 && q.mode != rmrp_pkg::sleep_state |=> $stable(modem_select_o);
   endproperty
   a_modem_hold: assert property (p_modem_hold) else $error("modem select moved");

   property p_ext_wait;
      @(posedge core_clk_i) disable iff (!resetn_i)
      access && is_ext && !bad && q.bus == rmrp_pkg::bus_idle
      |-> !pready_o ##1 pready_o && ext_req_o;
   endproperty
   a_ext_wait: assert property (p_ext_wait) else $error("modem page wait wrong");

   property p_fsk_page;
      @(posedge core_clk_i) disable iff (!resetn_i)
      ext_req_o && !modem_select_o |-> ext_fsk_page_o;
   endproperty
   a_fsk_page: assert property (p_fsk_page) else $error("shared bit used in fsk");

   property p_band_write;
      @(posedge core_clk_i) disable iff (!resetn_i)
      wr_local && idx == 7'h01 |=> band_bank_select_o == $past(pwdata_i[3]);
   endproperty
   a_band_write: assert property (p_band_write) else $error("band bit not written");

   property p_band_keep;
      @(posedge core_clk_i) disable iff (!resetn_i)
      $changed(band_bank_select_o) |-> $stable(q.bank);
   endproperty
   a_band_keep: assert property (p_band_keep) else $error("bank lost on band switch");

   property p_fifo_write_sleep;
      @(posedge core_clk_i) disable iff (!resetn_i)
      access && pwrite_i && idx == 7'h00 && mode_o == 3'h0 |=> q.fifo_data == 8'h00;
   endproperty
   a_fifo_write_sleep: assert property (p_fifo_write_sleep) else $error("fifo written asleep");

   property p_bw_write;
      @(posedge core_clk_i) disable iff (!resetn_i)
      wr_local && idx == 7'h70 |=> synth_loop_bandwidth_o == $past(pwdata_i[7:6]);
   endproperty
   a_bw_write: assert property (p_bw_write) else $error("bandwidth not written");

   property p_floor_write;
      @(posedge core_clk_i) disable iff (!resetn_i)
      wr_local && idx == 7'h61 |=> gain_floor_level_o == $past(pwdata_i[5:0]);
   endproperty
   a_floor_write: assert property (p_floor_write) else $error("gain floor not written");

endmodule

// ===== sim/rmrp_modem_page_model.sv
// ----------------------------------------------------------------
// far-side modem pages: separate fsk and long-range byte stores
// ----------------------------------------------------------------
module rmrp_modem_page_model (
   input  wire logic       core_clk_i,
   input  wire logic       ext_req_i,
   input  wire logic       ext_we_i,
   input  wire logic [6:0] ext_addr_i,
   input  wire logic [7:0] ext_wdata_i,
   input  wire logic       ext_fsk_page_i,
   output      logic [7:0] ext_rdata_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] page_mem [0:255];
   logic [7:0] last_q;

   initial begin
      for (int i = 0; i < 256; i++) page_mem[i] = 8'h00;
      last_q = 8'h00;
   end

   // data only while the request stands, so a late sample sees a flipped byte
   assign ext_rdata_o = ext_req_i ? page_mem[{ext_fsk_page_i, ext_addr_i}] : ~last_q;

   // the page tag picks the store, so a wrong tag reads the other page
   always @(posedge core_clk_i) begin
      if (ext_req_i) begin
         last_q <= page_mem[{ext_fsk_page_i, ext_addr_i}];
         if (ext_we_i) page_mem[{ext_fsk_page_i, ext_addr_i}] <= ext_wdata_i;
      end
   end
endmodule

// ===== sim/tb_radio_mode_register_paging.sv
module tb_radio_mode_register_paging;
   timeunit 1ns;
   timeprecision 100ps;

   logic        core_clk_i = 1'b0, resetn_i = 1'b0;
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [8:0]  paddr_i = 9'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o;
   logic        pready_o, pslverr_o, ext_req_o, ext_we_o, ext_fsk_page_o;
   logic [6:0]  ext_addr_o;
   logic [7:0]  ext_wdata_o, ext_rdata_i, carrier_freq_high_o;
   logic        modem_select_o, band_bank_select_o, mode_start_o;
   logic [2:0]  mode_o;
   logic [5:0]  gain_floor_level_o;
   logic [4:0]  gain_threshold_first_o;
   logic [3:0]  gain_threshold_second_o, gain_threshold_third_o;
   logic [3:0]  gain_threshold_fourth_o, gain_threshold_fifth_o;
   logic [1:0]  synth_loop_bandwidth_o;
   logic [31:0] rd;
   logic        err;
   int          num_errors = 0;
   int          compares = 0;

   rmrp_regs uut (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .ext_req_o(ext_req_o), .ext_we_o(ext_we_o),
      .ext_addr_o(ext_addr_o), .ext_wdata_o(ext_wdata_o),
      .ext_fsk_page_o(ext_fsk_page_o), .ext_rdata_i(ext_rdata_i),
      .modem_select_o(modem_select_o), .band_bank_select_o(band_bank_select_o),
      .mode_o(mode_o), .mode_start_o(mode_start_o),
      .carrier_freq_high_o(carrier_freq_high_o), .gain_floor_level_o(gain_floor_level_o),
      .gain_threshold_first_o(gain_threshold_first_o),
      .gain_threshold_second_o(gain_threshold_second_o),
      .gain_threshold_third_o(gain_threshold_third_o),
      .gain_threshold_fourth_o(gain_threshold_fourth_o),
      .gain_threshold_fifth_o(gain_threshold_fifth_o),
      .synth_loop_bandwidth_o(synth_loop_bandwidth_o));

   rmrp_modem_page_model far_side (
      .core_clk_i(core_clk_i), .ext_req_i(ext_req_o), .ext_we_i(ext_we_o),
      .ext_addr_i(ext_addr_o), .ext_wdata_i(ext_wdata_o),
      .ext_fsk_page_i(ext_fsk_page_o), .ext_rdata_o(ext_rdata_i));

   // free-running core clock, 5 ns period
   initial begin
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   // ----------------------------------------------------------------
   // report and compare
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // ----------------------------------------------------------------
   // apb master: setup, access held until pready, release after it
   // ----------------------------------------------------------------
   task automatic apb(input logic wr, input logic [6:0] idx, input logic [7:0] wd,
                      output logic [31:0] rdata, output logic serr);
      int n;
      n = 0;
      @(posedge core_clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= {idx, 2'b00};
      pwdata_i <= {24'h000000, wd};
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 40);
      if (pready_o !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
      rdata = prdata_o;
      serr  = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [6:0] idx, input logic [7:0] wd);
      apb(1'b1, idx, wd, rd, err);
   endtask

   task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00, rd, err);
      check($sformatf("reg %h", idx), {24'h000000, exp}, rd);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      rd_chk(7'h01, 8'h09);
      check("lf bank", 32'h1, {31'h0, band_bank_select_o});
      rd_chk(7'h06, 8'h6c);
      check("carrier", 32'h6c, {24'h0, carrier_freq_high_o});
      rd_chk(7'h61, 8'h19);
      wr(7'h01, 8'h01);
      check("hf bank", 32'h0, {31'h0, band_bank_select_o});
      rd_chk(7'h61, 8'h1c);
      rd_chk(7'h62, 8'h0e);
      rd_chk(7'h63, 8'h5b);
      rd_chk(7'h64, 8'hcc);
      rd_chk(7'h70, 8'hd0);
      check("gain fields", {5'h00, 6'h1c, 5'h0e, 4'h5, 4'hb, 4'hc, 4'hc},
            {5'h00, gain_floor_level_o, gain_threshold_first_o, gain_threshold_second_o,
             gain_threshold_third_o, gain_threshold_fourth_o, gain_threshold_fifth_o});
      wr(7'h61, 8'hff);
      rd_chk(7'h61, 8'h3f);
      wr(7'h02, 8'hff);
      rd_chk(7'h02, 8'h00);
      rd_chk(7'h65, 8'h00);
      wr(7'h01, 8'h39);
      rd_chk(7'h01, 8'h09);
      rd_chk(7'h61, 8'h19);
      wr(7'h01, 8'h01);
      rd_chk(7'h61, 8'h3f);
      for (int b = 0; b < 4; b++) begin
         wr(7'h70, {b[1:0], 6'h10});
         check("bandwidth", b, {30'h0, synth_loop_bandwidth_o});
      end
      for (int m = 0; m < 8; m++) begin
         wr(7'h01, {5'h01, m[2:0]});
         check("mode", m, {29'h0, mode_o});
         check("start", 32'h1, {31'h0, mode_start_o});
         @(posedge core_clk_i);
         #1;
         check("start end", 32'h0, {31'h0, mode_start_o});
      end
      // fsk page contents, written while fsk is selected
      wr(7'h10, 8'ha1);
      wr(7'h0d, 8'he7);
      wr(7'h40, 8'hc4);
      wr(7'h01, 8'h89);
      rd_chk(7'h01, 8'h09);
      wr(7'h00, 8'h5a);
      rd_chk(7'h00, 8'h5a);
      wr(7'h01, 8'h08);
      apb(1'b1, 7'h00, 8'h33, rd, err);
      check("fifo refused", 32'h1, {31'h0, err});
      wr(7'h01, 8'h89);
      rd_chk(7'h01, 8'h89);
      check("long range", 32'h1, {31'h0, modem_select_o});
      rd_chk(7'h00, 8'h00);
      wr(7'h10, 8'hb2);
      wr(7'h40, 8'hd5);
      rd_chk(7'h10, 8'hb2);
      wr(7'h01, 8'hc9);
      rd_chk(7'h10, 8'ha1);
      rd_chk(7'h0d, 8'he7);
      rd_chk(7'h40, 8'hd5);
      wr(7'h01, 8'h89);
      rd_chk(7'h10, 8'hb2);
      wr(7'h01, 8'h88);
      wr(7'h01, 8'h49);
      rd_chk(7'h01, 8'h49);
      rd_chk(7'h40, 8'hc4);
      tally_and_finish();
   end
endmodule
